// [core/rmr_cfg_if.sv]
// configuration carrier between the register core and its decoders
// assumes one clock domain; all signals are plain levels
`timescale 1ns/1ps
`include "rmr_defs.svh"
interface rmr_cfg_if;
	logic draw_addr_sel;
	logic mem_width_sel;
	logic [2:0] pixel_depth_mode;
	logic [`RMR_ADDR_W-1:0] disp_addr;
	logic [`RMR_ADDR_W-1:0] draw_addr;
	rmr_pkg::rmr_depth_t depth;
	logic [`RMR_ADDR_W-1:0] origin;
	logic [`RMR_XW_W-1:0] x_width;

	modport core (output draw_addr_sel, mem_width_sel, pixel_depth_mode, disp_addr, draw_addr,
		input depth, origin, x_width);
	modport dec (input pixel_depth_mode, output depth);
	modport org (input draw_addr_sel, mem_width_sel, disp_addr, draw_addr, output origin, x_width);
endinterface : rmr_cfg_if

// [core/rmr_defs.svh]
// constants for the rendering mode register block
// assumes a 32-bit avalon-mm slave port with byte addressing
`ifndef RMR_DEFS_SVH
`define RMR_DEFS_SVH

`define RMR_AW 4
`define RMR_DW 32
`define RMR_BEW 4
`define RMR_REG_W 16
`define RMR_ADDR_W 20
`define RMR_XW_W 11

`define RMR_OFS_MODE 4'h0
`define RMR_OFS_STAT 4'h4

`define RMR_SEL_BIT 15
`define RMR_MW_BIT 6
`define RMR_DM_HI 2
`define RMR_DM_LO 0
`define RMR_RSV_HI_TOP 14
`define RMR_RSV_HI_BOT 7
`define RMR_RSV_LO_TOP 5
`define RMR_RSV_LO_BOT 3
`define RMR_BE_SEL 1
`define RMR_BE_LOW 0

`define RMR_ST_BUSY_WR 0
`define RMR_ST_CONFLICT 1
`define RMR_ST_BUSY 2
`define RMR_ST_FG16 3
`define RMR_ST_BG16 4
`define RMR_ST_RND16 5

`define RMR_SEL_RESET 1'h0
`define RMR_FLAG_RESET 1'h0
`define RMR_XW_NARROW 11'h200
`define RMR_XW_WIDE 11'h400

`endif

// [core/rmr_depth_dec.sv]
// per-layer pixel depth decoder
// assumes the depth code is held stable by the register core
`timescale 1ns/1ps
module rmr_depth_dec (
	rmr_cfg_if.dec cfg // depth code in, layer depths out
);
	always_comb begin
		cfg.depth = rmr_pkg::rmr_decode_depth(cfg.pixel_depth_mode);
	end
endmodule : rmr_depth_dec

// [core/rmr_origin_sel.sv]
// drawing origin select and frame memory x width
// assumes both start addresses come from registers elsewhere in the device
`timescale 1ns/1ps
`include "rmr_defs.svh"
module rmr_origin_sel (
	rmr_cfg_if.org cfg // select bits in, origin and width out
);
	always_comb begin
		cfg.origin = cfg.draw_addr_sel ? cfg.draw_addr : cfg.disp_addr;
		cfg.x_width = cfg.mem_width_sel ? `RMR_XW_WIDE : `RMR_XW_NARROW;
	end
endmodule : rmr_origin_sel

// [core/rmr_pkg.sv]
// types and shared decode functions for the rendering mode register block
// assumes rmr_defs.svh for field positions
package rmr_pkg;
	typedef enum logic [1:0] {
		RMR_IDLE = 2'b01,
		RMR_ACK = 2'b10
	} rmr_bus_state_t;

	typedef struct packed {
		logic fg_16;
		logic bg_16;
		logic rnd_16;
	} rmr_depth_t;

	// one bit per layer: 1 means 16 bits/pixel, 0 means 8 bits/pixel
	function automatic rmr_depth_t rmr_decode_depth(input logic [2:0] code);
		rmr_depth_t d;
		case (code)
			3'h0: d = '{1'b0, 1'b0, 1'b0};
			3'h1: d = '{1'b1, 1'b1, 1'b1};
			3'h2: d = '{1'b0, 1'b1, 1'b0};
			3'h3: d = '{1'b1, 1'b0, 1'b1};
			3'h4: d = '{1'b0, 1'b0, 1'b1};
			3'h5: d = '{1'b1, 1'b1, 1'b0};
			3'h6: d = '{1'b0, 1'b1, 1'b1};
			default: d = '{1'b1, 1'b0, 1'b0};
		endcase
		return d;
	endfunction : rmr_decode_depth

	// split rendering depth needs the separate drawing origin
	function automatic logic rmr_sel_conflict(input logic sel, input logic [2:0] code);
		return !sel && code[2];
	endfunction : rmr_sel_conflict
endpackage : rmr_pkg

// [core/rmr_top.sv]
// rendering mode register with avalon-mm slave and display-list write port
// assumes synchronous inputs, one clock, master holds requests until waitrequest low
`timescale 1ns/1ps
`include "rmr_defs.svh"
module rmr_top (
	input wire logic clock, // 40 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire logic [`RMR_AW-1:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [`RMR_DW-1:0] avs_writedata, // write data
	input wire logic [`RMR_BEW-1:0] avs_byteenable, // write byte lanes
	output logic [`RMR_DW-1:0] avs_readdata, // read data
	output logic avs_waitrequest, // high until the answer
	input wire logic dl_wr, // display-list register write strobe
	input wire logic [`RMR_REG_W-1:0] dl_wr_data, // display-list register write value
	input wire logic draw_busy, // drawing engine running
	input wire logic [`RMR_ADDR_W-1:0] disp_start_addr, // display start address
	input wire logic [`RMR_ADDR_W-1:0] draw_start_addr, // drawing start address
	output logic draw_addr_sel, // stored origin select
	output logic mem_width_sel, // stored memory width select
	output logic [2:0] pixel_depth_mode, // stored depth code
	output logic fg_16bpp, // foreground at 16 bits/pixel
	output logic bg_16bpp, // background at 16 bits/pixel
	output logic rnd_16bpp, // rendering at 16 bits/pixel
	output logic [`RMR_XW_W-1:0] x_width, // frame memory x width in pixels
	output logic [`RMR_ADDR_W-1:0] draw_origin // drawing area start address
);
	rmr_pkg::rmr_bus_state_t state;
	rmr_pkg::rmr_bus_state_t next_state;
	logic busy_wr;
	logic bus_req;
	logic wr_mode;
	logic wr_stat;
	logic rd_mode;
	logic [`RMR_DW-1:0] next_readdata;
	rmr_pkg::rmr_depth_t exp_depth;

	rmr_cfg_if cfg ();

	assign cfg.draw_addr_sel = draw_addr_sel;
	assign cfg.mem_width_sel = mem_width_sel;
	assign cfg.pixel_depth_mode = pixel_depth_mode;
	assign cfg.disp_addr = disp_start_addr;
	assign cfg.draw_addr = draw_start_addr;

	rmr_depth_dec u_depth (
		.cfg(cfg.dec)
	);

	rmr_origin_sel u_origin (
		.cfg(cfg.org)
	);

	// ---- bus handshake ----
	assign bus_req = avs_read || avs_write;
	// writes commit only at the edge where waitrequest is seen low
	assign wr_mode = (state == rmr_pkg::RMR_ACK) && avs_write && (avs_address == `RMR_OFS_MODE);
	assign wr_stat = (state == rmr_pkg::RMR_ACK) && avs_write && (avs_address == `RMR_OFS_STAT);
	assign rd_mode = (state == rmr_pkg::RMR_IDLE) && avs_read && (avs_address == `RMR_OFS_MODE);

	always_comb begin
		case (state)
			rmr_pkg::RMR_IDLE: next_state = bus_req ? rmr_pkg::RMR_ACK : rmr_pkg::RMR_IDLE;
			rmr_pkg::RMR_ACK: next_state = rmr_pkg::RMR_IDLE;
			default: next_state = rmr_pkg::RMR_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= rmr_pkg::RMR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((state == rmr_pkg::RMR_IDLE) && bus_req);
		end
	end

	// ---- read mux; reserved and unmapped bits read zero ----
	always_comb begin
		next_readdata = '0;
		case (avs_address)
			`RMR_OFS_MODE: begin
				next_readdata[`RMR_SEL_BIT] = draw_addr_sel;
				next_readdata[`RMR_MW_BIT] = mem_width_sel;
				next_readdata[`RMR_DM_HI:`RMR_DM_LO] = pixel_depth_mode;
			end
			`RMR_OFS_STAT: begin
				next_readdata[`RMR_ST_BUSY_WR] = busy_wr;
				next_readdata[`RMR_ST_CONFLICT] = rmr_pkg::rmr_sel_conflict(draw_addr_sel, pixel_depth_mode);
				next_readdata[`RMR_ST_BUSY] = draw_busy;
				next_readdata[`RMR_ST_FG16] = fg_16bpp;
				next_readdata[`RMR_ST_BG16] = bg_16bpp;
				next_readdata[`RMR_ST_RND16] = rnd_16bpp;
			end
			default: next_readdata = '0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			avs_readdata <= '0;
		end else if ((state == rmr_pkg::RMR_IDLE) && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

	// ---- origin select: the only mode register field cleared by reset ----
	// a display-list write wins over a bus write in the same cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			draw_addr_sel <= `RMR_SEL_RESET;
		end else if (dl_wr) begin
			draw_addr_sel <= dl_wr_data[`RMR_SEL_BIT];
		end else if (wr_mode && avs_byteenable[`RMR_BE_SEL]) begin
			draw_addr_sel <= avs_writedata[`RMR_SEL_BIT];
		end
	end

	// width and depth carry no reset so they survive one; power-up value is unknown
	always_ff @(posedge clock) begin
		if (!reset && dl_wr) begin
			mem_width_sel <= dl_wr_data[`RMR_MW_BIT];
			pixel_depth_mode <= dl_wr_data[`RMR_DM_HI:`RMR_DM_LO];
		end else if (!reset && wr_mode && avs_byteenable[`RMR_BE_LOW]) begin
			mem_width_sel <= avs_writedata[`RMR_MW_BIT];
			pixel_depth_mode <= avs_writedata[`RMR_DM_HI:`RMR_DM_LO];
		end
	end

	// ---- sticky flag: bus rewrite while drawing; write one to clear, set wins ----
	always_ff @(posedge clock) begin
		if (reset) begin
			busy_wr <= `RMR_FLAG_RESET;
		end else if (wr_mode && draw_busy) begin
			busy_wr <= 1'b1;
		end else if (wr_stat && avs_byteenable[`RMR_BE_LOW] && avs_writedata[`RMR_ST_BUSY_WR]) begin
			busy_wr <= 1'b0;
		end
	end

	// ---- engine-facing copies, registered so outputs leave flops ----
	always_ff @(posedge clock) begin
		fg_16bpp <= cfg.depth.fg_16;
		bg_16bpp <= cfg.depth.bg_16;
		rnd_16bpp <= cfg.depth.rnd_16;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			// both restart from quiet values; the mux refills them one cycle after release
			draw_origin <= '0;
			x_width <= `RMR_XW_NARROW;
		end else begin
			draw_origin <= cfg.origin;
			x_width <= cfg.x_width;
		end
	end

	// ---- checks ----
	// expected depths by bit pattern: foreground follows bit 0, the others differ from it by bit 1 or bit 2
	assign exp_depth = {pixel_depth_mode[`RMR_DM_LO], ^pixel_depth_mode[`RMR_DM_LO+1:`RMR_DM_LO],
		pixel_depth_mode[`RMR_DM_HI] ^ pixel_depth_mode[`RMR_DM_LO]};

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// width and depth come up unknown after power-up, so checks that can see them before a write use case equality
	// disable iff sees the reset already released on its last edge, so such attempts carry !reset

	sequence s_req_idle;
		(state == rmr_pkg::RMR_IDLE) && bus_req;
	endsequence

	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	sequence s_rd_mode;
		rd_mode;
	endsequence

	sequence s_rd_stat;
		(state == rmr_pkg::RMR_IDLE) && avs_read && (avs_address == `RMR_OFS_STAT);
	endsequence

	sequence s_rd_other;
		(state == rmr_pkg::RMR_IDLE) && avs_read && (avs_address != `RMR_OFS_MODE)
			&& (avs_address != `RMR_OFS_STAT);
	endsequence

	sequence s_dl_write;
		dl_wr && !reset;
	endsequence

	a_bus_answer_time: assert property (s_req_idle |=> s_answer)
		else $error("bus request not answered in one cycle");

	a_mode_readback: assert property (s_rd_mode |=>
		avs_readdata[`RMR_SEL_BIT] == $past(draw_addr_sel)
		&& avs_readdata[`RMR_MW_BIT] === $past(mem_width_sel)
		&& avs_readdata[`RMR_DM_HI:`RMR_DM_LO] === $past(pixel_depth_mode))
		else $error("mode register read back wrong");

	a_reserved_read_zero: assert property (s_rd_mode |=>
		avs_readdata[`RMR_RSV_HI_TOP:`RMR_RSV_HI_BOT] == '0
		&& avs_readdata[`RMR_RSV_LO_TOP:`RMR_RSV_LO_BOT] == '0
		&& avs_readdata[`RMR_DW-1:`RMR_REG_W] == '0)
		else $error("reserved bits read nonzero");

	a_sel_write_takes: assert property (wr_mode && !dl_wr && avs_byteenable[`RMR_BE_SEL]
		|=> draw_addr_sel == $past(avs_writedata[`RMR_SEL_BIT]))
		else $error("origin select not written");

	a_sel_lane_guard: assert property (wr_mode && !dl_wr && !avs_byteenable[`RMR_BE_SEL]
		|=> $stable(draw_addr_sel))
		else $error("origin select written with its byte lane off");

	a_lane0_write_takes: assert property (wr_mode && !dl_wr && avs_byteenable[`RMR_BE_LOW]
		|=> mem_width_sel == $past(avs_writedata[`RMR_MW_BIT])
		&& pixel_depth_mode == $past(avs_writedata[`RMR_DM_HI:`RMR_DM_LO]))
		else $error("width or depth not written from the bus");

	a_dl_write_takes: assert property (s_dl_write |=>
		draw_addr_sel == $past(dl_wr_data[`RMR_SEL_BIT])
		&& mem_width_sel == $past(dl_wr_data[`RMR_MW_BIT])
		&& pixel_depth_mode == $past(dl_wr_data[`RMR_DM_HI:`RMR_DM_LO]))
		else $error("display-list write not taken");

	a_origin_follows: assert property (draw_addr_sel ##1 draw_addr_sel && $stable(draw_start_addr)
		|-> draw_origin == draw_start_addr)
		else $error("drawing origin not from drawing start address");

	a_origin_select: assert property (!reset |=> draw_origin
		== ($past(draw_addr_sel) ? $past(draw_start_addr) : $past(disp_start_addr)))
		else $error("drawing origin mux wrong");

	a_xwidth_follows: assert property (##1 !$past(reset)
		|-> x_width === ($past(mem_width_sel) ? `RMR_XW_WIDE : `RMR_XW_NARROW))
		else $error("frame memory x width wrong");

	a_depth_decode: assert property (##1 1'b1
		|-> {fg_16bpp, bg_16bpp, rnd_16bpp} === $past(exp_depth))
		else $error("layer depth decode wrong");

	a_reset_clears_sel: assert property ($fell(reset) |-> !draw_addr_sel)
		else $error("reset left origin select set");

	a_reset_keeps_mode: assert property (disable iff (1'b0) reset |=>
		mem_width_sel === $past(mem_width_sel) && pixel_depth_mode === $past(pixel_depth_mode))
		else $error("reset changed width or depth");

	a_reset_outputs: assert property (disable iff (1'b0) reset |=>
		avs_waitrequest && !busy_wr && !draw_addr_sel
		&& draw_origin == '0 && x_width == `RMR_XW_NARROW)
		else $error("reset left an output active");

	a_busy_flag_set: assert property (wr_mode && draw_busy |=> busy_wr [*2])
		else $error("rewrite while drawing not flagged");

	a_busy_flag_clear: assert property (wr_stat && avs_byteenable[`RMR_BE_LOW] && avs_writedata[`RMR_ST_BUSY_WR]
		|=> !busy_wr)
		else $error("busy write flag not cleared");

	a_busy_flag_hold: assert property (busy_wr && !wr_stat |=> busy_wr)
		else $error("busy write flag dropped by itself");

	a_status_readback: assert property (s_rd_stat |=>
		avs_readdata[`RMR_ST_BUSY_WR] == $past(busy_wr)
		&& avs_readdata[`RMR_ST_CONFLICT] === $past(!draw_addr_sel && pixel_depth_mode[`RMR_DM_HI])
		&& avs_readdata[`RMR_ST_BUSY] == $past(draw_busy)
		&& avs_readdata[`RMR_ST_RND16:`RMR_ST_FG16] === $past({rnd_16bpp, bg_16bpp, fg_16bpp})
		&& avs_readdata[`RMR_DW-1:`RMR_ST_RND16+1] == '0)
		else $error("status register read back wrong");

	a_unmapped_read_zero: assert property (s_rd_other |=> avs_readdata == '0)
		else $error("unmapped read nonzero");

	a_wait_when_idle: assert property ((state == rmr_pkg::RMR_IDLE) && !bus_req |=> avs_waitrequest)
		else $error("waitrequest low without a request");
endmodule : rmr_top

// [dv/rendering_mode_register_tb_top.sv]
// self-checking bench for the rendering mode register block
// assumes rmr_top with a 40 MHz clock and an avalon-mm slave answering after one cycle
`timescale 1ns/1ps
`include "rmr_defs.svh"
module rendering_mode_register_tb_top;
	logic clock, reset, avs_read, avs_write, avs_waitrequest, dl_wr, draw_busy;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] dl_wr_data;
	logic [19:0] disp_start_addr, draw_start_addr, draw_origin;
	logic draw_addr_sel, mem_width_sel, fg_16bpp, bg_16bpp, rnd_16bpp;
	logic [2:0] pixel_depth_mode;
	logic [10:0] x_width;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;

	rmr_top rmr_top_inst (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dl_wr(dl_wr), .dl_wr_data(dl_wr_data),
		.draw_busy(draw_busy), .disp_start_addr(disp_start_addr), .draw_start_addr(draw_start_addr),
		.draw_addr_sel(draw_addr_sel), .mem_width_sel(mem_width_sel), .pixel_depth_mode(pixel_depth_mode),
		.fg_16bpp(fg_16bpp), .bg_16bpp(bg_16bpp), .rnd_16bpp(rnd_16bpp), .x_width(x_width),
		.draw_origin(draw_origin));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			$display("unexpected at %0t: run timed out", $time);
			error_cnt = error_cnt + 1;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// one avalon transfer; read data taken at the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// wait for decoded outputs, then compare every stored field and the readback
	task automatic check_mode(input logic [15:0] v);
		repeat (2) @(posedge clock);
		#1;
		chk(draw_addr_sel, v[15], "select");
		chk(mem_width_sel, v[6], "width bit");
		chk(x_width, v[6] ? 11'h400 : 11'h200, "x width");
		chk(pixel_depth_mode, v[2:0], "depth code");
		chk({fg_16bpp, bg_16bpp, rnd_16bpp}, {v[0], v[0] ^ v[1], v[0] ^ v[2]}, "layer depths");
		chk(draw_origin, v[15] ? draw_start_addr : disp_start_addr, "origin");
		bus(1'b0, `RMR_OFS_MODE, 32'h0, rd);
		chk(rd, {16'h0, v & 16'h8047}, "readback");
	endtask : check_mode

	task automatic t_depth_codes();
		logic [15:0] v;
		for (int c = 0; c < 8; c++) begin
			v = {1'b1, 8'h00, c[0], 3'h0, c[2:0]};
			bus(1'b1, `RMR_OFS_MODE, {16'h0, v}, rd);
			check_mode(v);
		end
	endtask : t_depth_codes

	task automatic t_origin();
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_0001, rd);
		check_mode(16'h0001);
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8041, rd);
		check_mode(16'h8041);
	endtask : t_origin

	task automatic t_reserved();
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8047, rd);
		check_mode(16'h8047);
		bus(1'b1, 4'h8, 32'h0, rd);
		bus(1'b0, 4'h8, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		check_mode(16'h8047);
	endtask : t_reserved

	task automatic t_reset();
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8045, rd);
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		check_mode(16'h0045);
	endtask : t_reset

	// display-list write while drawing keeps width and the displayed layer depths
	task automatic t_display_list();
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8045, rd);
		@(posedge clock);
		draw_busy <= 1'b1;
		dl_wr <= 1'b1;
		dl_wr_data <= 16'h8041;
		@(posedge clock);
		dl_wr <= 1'b0;
		check_mode(16'h8041);
		draw_busy <= 1'b0;
	endtask : t_display_list

	// rewrites the stored value while drawing, so the engines see no change and only the flag moves
	task automatic t_status();
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8045, rd);
		draw_busy <= 1'b1;
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_8045, rd);
		draw_busy <= 1'b0;
		bus(1'b0, `RMR_OFS_STAT, 32'h0, rd);
		chk(rd, 32'h0000_0019, "status after write while drawing");
		bus(1'b1, `RMR_OFS_STAT, 32'h0000_0001, rd);
		bus(1'b0, `RMR_OFS_STAT, 32'h0, rd);
		chk(rd, 32'h0000_0018, "status after flag clear");
		avs_byteenable <= 4'h1;
		bus(1'b1, `RMR_OFS_MODE, 32'h0000_0041, rd);
		avs_byteenable <= 4'hF;
		check_mode(16'h8041);
	endtask : t_status

	initial begin
		reset = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		dl_wr = 1'b0;
		dl_wr_data = 16'h0;
		draw_busy = 1'b0;
		disp_start_addr = 20'hABCDE;
		draw_start_addr = 20'h12345;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		t_depth_codes();
		t_origin();
		t_reserved();
		t_reset();
		t_display_list();
		t_status();
		complete_run();
	end
endmodule : rendering_mode_register_tb_top
